// file: wdt_defs.vh
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH
// Register byte offsets
`define OFF_CONTROL      5'h00
`define OFF_DIVIDER      5'h04
`define OFF_RELOAD       5'h08
`define OFF_COUNT        5'h0C
`define OFF_STATUS       5'h10
`define OFF_MASK         5'h14
`define OFF_KEY          5'h18
// Control field positions
`define CTL_LOCK_BIT     0
`define CTL_START_BIT    1
`define CTL_ALT_BIT      2
// Reset values
`define RST_CONTROL      3'h0
`define RST_DIVIDER      8'hFF
`define RST_RELOAD       16'hFFFF
`define RST_COUNT        16'hFFFF
`define RST_FLAG         1'b0
`define RST_MASK         1'b0
// Edges after reset release before the strap synchroniser holds a settled level
`define STRAP_SETTLE     2'h3
// Service keys
`define KEY_FIRST        16'hA55A
`define KEY_SECOND       16'h5AA5
// Alternate clock divide ratio minus one
`define ALT_DIV_LAST     3'h7
`endif

// file: wdt_timer.v
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.vh"
// Summary of operation
// - Unlocked, setting start_counting loads reload value and starts timer mode.
// - Timer mode: at zero raise end-of-count and reload automatically.
// - Timer runs while start_counting is one, stops when cleared.
// - Every new start reloads both counter and prescaler from preloads.
// - New divider value applies only at the next start, watchdog entry or key reload.
// - Control bit 2 selects bus clock or slower alternate clock.
// - Alternate count clock is rtc source clock divided by eight.
// - Clock select writable only while lock is clear, then frozen.
// - Writing lock bit 0 enters watchdog mode forever; start ignored.
// - Entering watchdog loads reload value; zero asserts system reset.
// - Key pair A55A then 5AA5 reloads the counter in watchdog mode.
// - Strap high sets lock by hardware after reset; else software once.
// - Reserved bits ignore writes and read zero.
// - Prescaler divides by divider value plus one, reset value FF.
// - Divider preload applies on watchdog entry, key reload, or start.
// - Live counter value readable in both modes.
// - Control register at offset zero resets to zero.
// - End-of-count flag set by hardware, cleared by software, not in watchdog.
// - End-of-count request only when mask bit is one.
// - Key writes ignored while unlocked; key register reads zero.
// - Reload value register resets to all ones.
module wdt_timer (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_b,
   // Classic Wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [4:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Clocks and straps from outside
   input  wire        rtc_source_clock,
   input  wire        strap_force_watchdog,
   // Results
   output reg         system_reset_out,
   output reg         end_of_count_irq
);

   // Software-visible state
   reg  [2:0]  control_reg;
   reg  [7:0]  divider_reg;
   reg  [15:0] reload_reg;
   reg         mask_reg;
   reg         flag_reg;
   reg         flag_next;

   // Counting state
   reg  [15:0] count_reg;
   reg  [15:0] count_next;
   reg  [7:0]  prescale_reg;
   reg  [7:0]  prescale_next;
   reg  [7:0]  prescale_top_reg;

   // Key sequence
   reg         key_armed_reg;
   reg         key_armed_next;

   // Rtc pin and alternate tick
   reg  [2:0]  rtc_sync_reg;
   reg         rtc_level_reg;
   reg  [2:0]  alt_div_reg;
   reg         alt_tick_reg;

   // Strap pin
   reg  [2:0]  strap_sync_reg;
   reg  [1:0]  strap_age_reg;
   reg         strap_done_reg;

   // Address match of a taken request
   function hit;
      input [4:0] a;
      input [4:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   wire        lock;
   wire        start;
   wire        alt_sel;
   wire        req;
   wire        wr;
   wire        wr_ctl;
   wire        wr_div;
   wire        wr_reload;
   wire        wr_status;
   wire        wr_mask;
   wire        wr_key;
   wire        rtc_agree;
   wire        rtc_rise;
   wire        tick_src;
   wire        strap_high;
   wire        strap_ready;
   wire        start_rise;
   wire        lock_rise;
   wire        key_done;
   wire        do_load;
   wire        running;
   wire        presc_end;
   wire        step;
   wire        at_zero;
   wire        status_clear;

   assign lock = control_reg[`CTL_LOCK_BIT];
   assign start = control_reg[`CTL_START_BIT];
   assign alt_sel = control_reg[`CTL_ALT_BIT];

   // Bus request decode; full words only, so sel is not consulted
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = req & wb_we_i;
   assign wr_ctl = wr & hit(wb_adr_i, `OFF_CONTROL);
   assign wr_div = wr & hit(wb_adr_i, `OFF_DIVIDER);
   assign wr_reload = wr & hit(wb_adr_i, `OFF_RELOAD);
   assign wr_status = wr & hit(wb_adr_i, `OFF_STATUS);
   assign wr_mask = wr & hit(wb_adr_i, `OFF_MASK);
   assign wr_key = wr & hit(wb_adr_i, `OFF_KEY) & lock;

   // A rtc change counts only once stages one and two agree
   assign rtc_agree = (rtc_sync_reg[1] == rtc_sync_reg[2]);
   assign rtc_rise = rtc_agree & rtc_sync_reg[2] & ~rtc_level_reg;
   assign tick_src = alt_sel ? alt_tick_reg : 1'b1;

   // Strap is judged once its synchroniser has settled after reset
   assign strap_high = strap_sync_reg[1] & strap_sync_reg[2];
   assign strap_ready = (strap_age_reg == `STRAP_SETTLE) & ~strap_done_reg;

   // Load events
   assign start_rise = wr_ctl & ~lock & wb_dat_i[`CTL_START_BIT] & ~start;
   assign lock_rise = ~lock & ((wr_ctl & wb_dat_i[`CTL_LOCK_BIT]) |
                      (strap_ready & strap_high));
   assign key_done = wr_key & key_armed_reg & (wb_dat_i[15:0] == `KEY_SECOND);
   assign do_load = start_rise | lock_rise | key_done;

   assign running = lock | start;
   assign presc_end = (prescale_reg == 8'h00);
   assign step = running & tick_src & presc_end & ~do_load;
   assign at_zero = step & (count_reg == 16'h0000);
   assign status_clear = wr_status & ~wb_dat_i[0];

   // Read multiplexer
   function [31:0] read_mux;
      input [4:0] a;
      begin
         case (a)
            `OFF_CONTROL: read_mux = {29'h0, control_reg};
            `OFF_DIVIDER: read_mux = {24'h0, divider_reg};
            `OFF_RELOAD:  read_mux = {16'h0, reload_reg};
            `OFF_COUNT:   read_mux = {16'h0, count_reg};
            `OFF_STATUS:  read_mux = {31'h0, flag_reg};
            `OFF_MASK:    read_mux = {31'h0, mask_reg};
            default:      read_mux = 32'h0000_0000;
         endcase
      end
   endfunction

   // Bus slave: one wait state, ack for one cycle, unmapped reads return zero
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         if (req) begin
            wb_dat_o <= wb_we_i ? 32'h0000_0000 : read_mux(wb_adr_i);
         end
      end
   end

   // Lock bit: set once, by software or strap, cleared only by reset
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         control_reg[`CTL_LOCK_BIT] <= 1'b0;
      end else if (lock_rise) begin
         control_reg[`CTL_LOCK_BIT] <= 1'b1;
      end
   end

   // Start and clock select freeze once locked
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         control_reg[`CTL_START_BIT] <= 1'b0;
         control_reg[`CTL_ALT_BIT] <= 1'b0;
      end else if (wr_ctl && !lock) begin
         control_reg[`CTL_START_BIT] <= wb_dat_i[`CTL_START_BIT];
         control_reg[`CTL_ALT_BIT] <= wb_dat_i[`CTL_ALT_BIT];
      end
   end

   // Divider preload; the running prescaler keeps its own top value
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         divider_reg <= `RST_DIVIDER;
      end else if (wr_div) begin
         divider_reg <= wb_dat_i[7:0];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reload_reg <= `RST_RELOAD;
      end else if (wr_reload) begin
         reload_reg <= wb_dat_i[15:0];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_reg <= `RST_MASK;
      end else if (wr_mask) begin
         mask_reg <= wb_dat_i[0];
      end
   end

   // Strap synchroniser; stage 0 feeds only stage 1
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_sync_reg <= 3'h0;
      end else begin
         strap_sync_reg <= {strap_sync_reg[1:0], strap_force_watchdog};
      end
   end

   // Strap is judged once, so a later strap change cannot lock the block
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_age_reg <= 2'h0;
         strap_done_reg <= 1'b0;
      end else begin
         if (strap_age_reg != `STRAP_SETTLE) begin
            strap_age_reg <= strap_age_reg + 2'h1;
         end
         if (strap_ready) begin
            strap_done_reg <= 1'b1;
         end
      end
   end

   // Key sequence detector; other writes between the two keys are allowed
   always @* begin
      key_armed_next = key_armed_reg;
      if (key_done) begin
         key_armed_next = 1'b0;
      end else if (wr_key) begin
         key_armed_next = (wb_dat_i[15:0] == `KEY_FIRST);
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         key_armed_reg <= 1'b0;
      end else begin
         key_armed_reg <= key_armed_next;
      end
   end

   // Rtc synchroniser; stage 0 feeds only stage 1
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rtc_sync_reg <= 3'h0;
         rtc_level_reg <= 1'b0;
      end else begin
         rtc_sync_reg <= {rtc_sync_reg[1:0], rtc_source_clock};
         if (rtc_agree) begin
            rtc_level_reg <= rtc_sync_reg[2];
         end
      end
   end

   // One tick pulse per eight settled rtc rising edges
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         alt_div_reg <= 3'h0;
         alt_tick_reg <= 1'b0;
      end else begin
         if (rtc_rise) begin
            alt_div_reg <= alt_div_reg + 3'h1;
         end
         alt_tick_reg <= rtc_rise & (alt_div_reg == `ALT_DIV_LAST);
      end
   end

   // Next prescaler and counter values
   always @* begin
      count_next = count_reg;
      prescale_next = prescale_reg;
      if (do_load) begin
         count_next = reload_reg;
         prescale_next = divider_reg;
      end else if (running && tick_src) begin
         if (presc_end) begin
            prescale_next = prescale_top_reg;
            if (count_reg == 16'h0000) begin
               count_next = reload_reg;
            end else begin
               count_next = count_reg - 16'h0001;
            end
         end else begin
            prescale_next = prescale_reg - 8'h01;
         end
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_reg <= `RST_COUNT;
         prescale_reg <= `RST_DIVIDER;
      end else begin
         count_reg <= count_next;
         prescale_reg <= prescale_next;
      end
   end

   // Division ratio is captured only at a load, never on the fly
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prescale_top_reg <= `RST_DIVIDER;
      end else if (do_load) begin
         prescale_top_reg <= divider_reg;
      end
   end

   // Flag: a zero in the same cycle as a clear wins
   always @* begin
      flag_next = flag_reg;
      if (status_clear) begin
         flag_next = 1'b0;
      end
      if (at_zero && !lock) begin
         flag_next = 1'b1;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_reg <= `RST_FLAG;
      end else begin
         flag_reg <= flag_next;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         end_of_count_irq <= 1'b0;
      end else begin
         end_of_count_irq <= flag_reg & mask_reg & ~lock;
      end
   end

   // System reset is latched; only rst_b releases it
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         system_reset_out <= 1'b0;
      end else if (at_zero && lock) begin
         system_reset_out <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// file: wdt_timer_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module wdt_timer_asserts (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_b,
   // Bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [4:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Results
   input wire logic        system_reset_out,
   input wire logic        end_of_count_irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   wire rq = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   AST_KEY_ZERO: assert property (rq && wb_adr_i == 5'h18 |=> wb_dat_o == 32'h0)
      else $error("key read nonzero");
   AST_CTRL_RSVD: assert property (rq && wb_adr_i == 5'h00 |=> wb_dat_o[31:3] == 29'h0)
      else $error("control reserved set");
   AST_DIV_RSVD: assert property (rq && wb_adr_i == 5'h04 |=> wb_dat_o[31:8] == 24'h0)
      else $error("divider reserved set");
   AST_CNT_WIDTH: assert property (rq && wb_adr_i inside {5'h08, 5'h0C}
      |=> wb_dat_o[31:16] == 16'h0) else $error("count too wide");
   AST_RST_HOLD: assert property (system_reset_out |=> system_reset_out [*2])
      else $error("reset dropped");
   AST_NO_IRQ: assert property (system_reset_out |-> !end_of_count_irq)
      else $error("event in watchdog");
endmodule
bind wdt_timer wdt_timer_asserts u_wdt_timer_asserts (.clk(clk), .rst_b(rst_b),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .system_reset_out(system_reset_out),
   .end_of_count_irq(end_of_count_irq));
`default_nettype wire

// file: wdt_timer_test.sv
`timescale 1ns/10ps
`default_nettype none
module wdt_timer_test;
   logic        clk, rst_b, cyc, we, rtc, strap;
   logic [4:0]  adr;
   logic [31:0] wdat, q, c;
   wire  [31:0] rdat;
   wire         ack, sysrst, irq;
   int          miscompares = 0, n_compared = 0, n;
   wdt_timer u_wdt_timer (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .rtc_source_clock(rtc), .strap_force_watchdog(strap),
      .system_reset_out(sysrst), .end_of_count_irq(irq));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Period of seven bus clocks; every rtc edge falls on a bus clock edge
   initial begin
      rtc = 1'b0;
      forever #87.5 rtc = ~rtc;
   end
   task automatic close_out;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %0t %h %h", $time, g, e);
      end
   endtask
   task automatic chk_pin(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask
   // Held until the rising edge that samples ack high; a lost ack counts as a mismatch
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do @(posedge clk); while (ack !== 1'b1 && ++n < 99);
      if (n >= 99) miscompares++;
      q = rdat;
      cyc <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wt(input logic s, input int m);
      n = 0;
      while ((s ? sysrst : irq) !== 1'b1 && n++ < m) @(negedge clk);
      @(posedge clk);
   endtask
   task automatic t_reset;
      logic [31:0] ev[8] = '{32'h0, 32'hFF, 32'hFFFF, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 8; i++) begin
         wb(1'b0, 5'(i * 4), 32'h0);
         chk(q, ev[i]);
      end
   endtask
   task automatic t_timer;
      wb(1'b1, 5'h04, 32'h0);
      wb(1'b1, 5'h08, 32'h3);
      wb(1'b1, 5'h00, 32'h2);
      repeat (20) @(posedge clk);
      chk_pin(irq, 1'b0);
      wb(1'b0, 5'h10, 32'h0);
      chk(q, 32'h1);
      wb(1'b1, 5'h14, 32'h1);
      wt(1'b0, 20);
      chk_pin(irq, 1'b1);
      wb(1'b1, 5'h00, 32'h0);
      wb(1'b1, 5'h10, 32'h0);
      wb(1'b0, 5'h10, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, 5'h0C, 32'h0);
      c = q;
      repeat (10) @(posedge clk);
      wb(1'b0, 5'h0C, 32'h0);
      chk(q, c);
      wb(1'b1, 5'h08, 32'h100);
      wb(1'b1, 5'h00, 32'h2);
      wb(1'b0, 5'h0C, 32'h0);
      chk_pin(q > 32'hF0 && q <= 32'h100, 1'b1);
      wb(1'b1, 5'h00, 32'h0);
   endtask
   task automatic t_alt;
      wb(1'b1, 5'h08, 32'h3);
      wb(1'b1, 5'h00, 32'h6);
      repeat (10) @(posedge clk);
      chk_pin(irq, 1'b0);
      wt(1'b0, 600);
      chk_pin(irq, 1'b1);
      wb(1'b1, 5'h00, 32'h0);
   endtask
   task automatic t_watchdog;
      wb(1'b1, 5'h08, 32'h40);
      wb(1'b1, 5'h00, 32'h1);
      for (int i = 0; i < 4; i++) begin
         repeat (30) @(posedge clk);
         wb(1'b1, 5'h18, 32'hA55A);
         wb(1'b1, 5'h18, 32'h5AA5);
      end
      chk_pin(sysrst, 1'b0);
      wb(1'b1, 5'h00, 32'h0);
      wb(1'b0, 5'h00, 32'h0);
      chk(q, 32'h1);
      wt(1'b1, 200);
      chk_pin(sysrst, 1'b1);
   endtask
   task automatic t_strap;
      rst_b <= 1'b0;
      strap <= 1'b1;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge clk);
      wb(1'b0, 5'h00, 32'h0);
      chk(q, 32'h1);
   endtask
   initial begin
      rst_b = 1'b0;
      cyc = 1'b0;
      we = 1'b0;
      adr = 5'h0;
      wdat = 32'h0;
      strap = 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset;
      t_timer;
      t_alt;
      t_watchdog;
      t_strap;
      close_out;
   end
   initial begin
      #200000;
      miscompares++;
      close_out;
   end
endmodule
`default_nettype wire
